// ### include/mspct_pkg.sv
// package: constants and types for the microstep phase-current table
package mspct_pkg;
  localparam int unsigned MSPCT_ENTRIES = 16;
  localparam int unsigned MSPCT_CODE_W = 6;
  localparam int unsigned MSPCT_IDX_W = 4;
  localparam int unsigned MSPCT_ANGLE_W = 6;
  localparam logic [5:0] MSPCT_CODE_MAX = 6'h3F;
  localparam logic [5:0] MSPCT_CODE_ZERO = 6'h00;
  localparam logic [5:0] MSPCT_PHASE_B_SHIFT = 6'h10;
  localparam logic [3:0] MSPCT_PEAK_ENTRY = 4'hF;
  localparam logic [3:0] MSPCT_PTR_RESET = 4'h0;
  // default sinusoidal profile, entry 15 first
  localparam logic [95:0] MSPCT_DEFAULT_TABLE = {
    6'h3F, 6'h3F, 6'h3E, 6'h3C, 6'h3A, 6'h37, 6'h34, 6'h30,
    6'h2C, 6'h28, 6'h23, 6'h1D, 6'h17, 6'h12, 6'h0B, 6'h05};

  typedef enum logic [3:0]
  {
    MSPCT_BR_OFF = 4'b0001,
    MSPCT_BR_DRIVE = 4'b0010,
    MSPCT_BR_FAST = 4'b0100,
    MSPCT_BR_SLOW = 4'b1000
  } mspct_bridge_t;

  // map angle 0..63 to table entry and zero flag, phase A geometry
  function automatic logic [4:0] mspct_map(input logic [5:0] angle);
    logic [4:0] off;
    logic [4:0] r;
    off = (angle[4:0] >= 5'h10) ? (angle[4:0] - 5'h10)
                                : (5'h10 - angle[4:0]);
    if (off == 5'h10)
      r = 5'h10;
    else
      r = {1'b0, 4'(5'hF - off)};
    return r;
  endfunction
endpackage

// ### include/mspct_bridge_if.sv
// interface: one H-bridge gate group plus its request
`timescale 1ns/10ps
interface mspct_bridge_if;
  logic neg;
  logic active;
  logic [1:0] decay;
  logic [3:0] gate;
  modport ctrl (output neg, output active, output decay, input gate);
  modport drv (input neg, input active, input decay, output gate);
endinterface

// ### design/mspct_bridge.sv
// H-bridge gate encoder for one phase
`timescale 1ns/10ps
module mspct_bridge
  import mspct_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  mspct_bridge_if.drv br
);
  // gate order {high_left, low_left, high_right, low_right}
  // decay: 00 sync fast, 01 sync slow, 10 nonsync fast, 11 nonsync slow
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      br.gate <= 4'h0;
    else if (br.active)
      br.gate <= br.neg ? 4'b0110 : 4'b1001;
    else
    begin
      case (br.decay)
        2'b00: br.gate <= br.neg ? 4'b1001 : 4'b0110;
        2'b01: br.gate <= 4'b0101;
        2'b10: br.gate <= 4'b0000;
        2'b11: br.gate <= br.neg ? 4'b0100 : 4'b0001;
        default: br.gate <= 4'h0;
      endcase
    end
  end
endmodule

// ### design/mspct_top.sv
// microstep phase-current table with bridge state selection
`timescale 1ns/10ps
module mspct_top
  import mspct_pkg::*;
#(
  parameter int unsigned CODE_W = MSPCT_CODE_W
)
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic load_valid_i,
  input wire logic [CODE_W-1:0] load_code_i,
  input wire logic load_restart_i,
  input wire logic [MSPCT_ANGLE_W-1:0] angle_i,
  input wire logic drive_a_i,
  input wire logic drive_b_i,
  input wire logic [1:0] decay_mode_i,
  output logic [CODE_W-1:0] current_a_o,
  output logic [CODE_W-1:0] current_b_o,
  output logic neg_a_o,
  output logic neg_b_o,
  output logic [3:0] gate_a_o,
  output logic [3:0] gate_b_o,
  output logic [MSPCT_IDX_W-1:0] load_ptr_o
);
  // ****************************************************
  // table storage and load pointer
  // ****************************************************
  logic [CODE_W-1:0] profile_entry_q [MSPCT_ENTRIES];
  logic [MSPCT_IDX_W-1:0] ptr_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      ptr_q <= MSPCT_PTR_RESET;
    else if (load_restart_i)
      ptr_q <= MSPCT_PTR_RESET;
    else if (load_valid_i)
      ptr_q <= ptr_q + 4'h1;
  end

  genvar gi;
  generate
    for (gi = 0; gi < MSPCT_ENTRIES; gi++)
    begin : g_entry
      always_ff @(posedge clk_sys_i)
      begin
        if (!rst_b_i)
          profile_entry_q[gi] <= CODE_W'(MSPCT_DEFAULT_TABLE[gi*6 +: 6]);
        else if (load_valid_i && !load_restart_i &&
                 ptr_q == MSPCT_IDX_W'(gi))
          profile_entry_q[gi] <= load_code_i;
      end
    end
  endgenerate

  // ****************************************************
  // angle to magnitude lookup
  // ****************************************************
  // phase B sits at angle plus sixteen on phase A's geometry, which
  // gives zeros at 16/48 and peaks at 0/32 with no second table
  logic [5:0] angle_b;
  logic [4:0] map_a;
  logic [4:0] map_b;
  assign angle_b = angle_i + MSPCT_PHASE_B_SHIFT;
  assign map_a = mspct_map(angle_i);
  assign map_b = mspct_map(angle_b);

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      current_a_o <= '0;
      current_b_o <= '0;
    end
    else
    begin
      // forced zero cannot be overwritten by any loaded code
      current_a_o <= map_a[4] ? '0 : profile_entry_q[map_a[3:0]];
      current_b_o <= map_b[4] ? '0 : profile_entry_q[map_b[3:0]];
    end
  end

  // ****************************************************
  // polarity and bridge drive
  // ****************************************************
  logic neg_a;
  logic neg_b;
  assign neg_a = angle_i[5];
  assign neg_b = angle_b[5];

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      neg_a_o <= 1'b0;
      neg_b_o <= 1'b0;
    end
    else
    begin
      neg_a_o <= neg_a;
      neg_b_o <= neg_b;
    end
  end

  mspct_bridge_if br_a ();
  mspct_bridge_if br_b ();
  assign br_a.neg = neg_a;
  assign br_a.active = drive_a_i;
  assign br_a.decay = decay_mode_i;
  assign br_b.neg = neg_b;
  assign br_b.active = drive_b_i;
  assign br_b.decay = decay_mode_i;

  mspct_bridge u_bridge_a (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .br(br_a)
  );
  mspct_bridge u_bridge_b (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .br(br_b)
  );

  assign gate_a_o = br_a.gate;
  assign gate_b_o = br_b.gate;
  assign load_ptr_o = ptr_q;
endmodule

// ### dv/mspct_assertions.sv
// checker: zero points, polarity and bridge gates of phase A
`timescale 1ns/10ps
module mspct_assertions
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [5:0] angle_i,
  input wire logic drive_a_i,
  input wire logic [1:0] decay_mode_i,
  input wire logic [5:0] current_a_o,
  input wire logic neg_a_o,
  input wire logic [3:0] gate_a_o
);
  logic [2:0] md;
  assign md = {drive_a_i, decay_mode_i};
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  property p_z; angle_i[4:0] == 5'h00 |=> current_a_o == 6'h00; endproperty
  a_z: assert property (p_z) else $error("zero");
  property p_n; 1'b1 |=> neg_a_o == $past(angle_i[5]); endproperty
  a_n: assert property (p_n) else $error("sign");
  property p_rp; md[2] && !angle_i[5] |=> gate_a_o == 4'h9; endproperty
  a_rp: assert property (p_rp) else $error("ramp");
  property p_rn; md[2] && angle_i[5] |=> gate_a_o == 4'h6; endproperty
  a_rn: assert property (p_rn) else $error("ramp");
  // decay gates follow the registered polarity of the same cycle
  property p_f; md == 3'h0 |=> gate_a_o == (neg_a_o ? 4'h9 : 4'h6); endproperty
  a_f: assert property (p_f) else $error("fast");
  property p_s; md == 3'h1 |=> gate_a_o == 4'h5; endproperty
  a_s: assert property (p_s) else $error("slow");
  property p_o; md == 3'h2 |=> gate_a_o == 4'h0; endproperty
  a_o: assert property (p_o) else $error("off");
  property p_l; md == 3'h3 |=> gate_a_o == (neg_a_o ? 4'h4 : 4'h1); endproperty
  a_l: assert property (p_l) else $error("ns slow");
endmodule
bind mspct_top mspct_assertions u_chk (.*);

// ### dv/mspct_host.sv
// host model: writes a sixteen-entry profile, entry 0 first
`timescale 1ns/10ps
module mspct_host
(
  input wire logic clk_sys_i,
  input wire logic go_i,
  input wire logic [95:0] prof_i,
  output logic load_valid_o = 1'b0,
  output logic [5:0] load_code_o = 6'h00
);
  always @(posedge go_i)
  begin
    for (int i = 0; i < 16; i++)
    begin
      {load_valid_o, load_code_o} = {1'b1, prof_i[6 * i +: 6]};
      @(posedge clk_sys_i) #1;
    end
    // a released code line must not keep its last value
    {load_valid_o, load_code_o} = {1'b0, ~load_code_o};
  end
endmodule

// ### dv/tb_top.sv
// testbench: default and loaded current tables with a gate mode sweep
`timescale 1ns/10ps
module tb_top;
  logic clk_sys_i = 0, rst_b_i = 0, go = 0, load_restart_i = 0;
  logic drive_a_i = 0, drive_b_i = 0, load_valid_i, neg_a_o, neg_b_o;
  logic [5:0] load_code_i, angle_i = 0, current_a_o, current_b_o;
  logic [1:0] decay_mode_i = 0;
  logic [3:0] gate_a_o, gate_b_o, load_ptr_o;
  logic [95:0] prof = mspct_pkg::MSPCT_DEFAULT_TABLE;
  int mismatches = 0, num_checks = 0;
  mspct_top u_dut (.*);
  mspct_host u_host (.clk_sys_i, .go_i(go), .prof_i(prof),
    .load_valid_o(load_valid_i), .load_code_o(load_code_i));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  task automatic chk(logic [5:0] g, logic [5:0] e);
    num_checks++;
    if (g !== e)
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    mismatches += int'(g !== e);
  endtask
  // upper half checks phase B, which reads the table sixteen angles on
  task automatic sweep();
    logic [4:0] o;
    logic [5:0] e;
    logic n;
    logic [3:0] g;
    for (int a = 0; a < 128; a++)
    begin
      {drive_a_i, decay_mode_i} = 3'(a);
      drive_b_i = a[2];
      angle_i = 6'(a);
      o = 5'(a) + (a[6] ? 5'h10 : 5'h00);
      o = o[4] ? o - 5'h10 : 5'h10 - o;
      e = o[4] ? 6'h00 : prof[6 * (5'hF - o) +: 6];
      // phase B is negative from angle 16 to 47, phase A from 32 to 63
      n = a[6] ? (6'(a) >= 6'h10 && 6'(a) < 6'h30) : (6'(a) >= 6'h20);
      if (a[2])
        g = n ? 4'h6 : 4'h9;
      else
      begin
        case (a[1:0])
          0: g = n ? 4'h9 : 4'h6;
          1: g = 4'h5;
          2: g = 4'h0;
          default: g = n ? 4'h4 : 4'h1;
        endcase
      end
      repeat (2) @(posedge clk_sys_i) #1;
      chk(a[6] ? current_b_o : current_a_o, e);
      chk({5'h00, a[6] ? neg_b_o : neg_a_o}, {5'h00, n});
      chk({2'h0, a[6] ? gate_b_o : gate_a_o}, {2'h0, g});
    end
  endtask
  task automatic t_load();
    prof = 96'hFFFFBCEB2A2381F79D71950A;
    go = 1;
    @(posedge clk_sys_i) #1;
    for (int i = 0; i < 20 && load_valid_i !== 1'b0; i++)
      @(posedge clk_sys_i) #1;
    if (load_valid_i !== 1'b0)
      conclude(1);
    chk({2'h0, load_ptr_o}, 6'h00);
    sweep();
  endtask
  task automatic conclude(int to);
    mismatches += to;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys_i) #1;
    rst_b_i = 1;
    chk({2'h0, load_ptr_o}, 6'h00);
    sweep();
    t_load();
    conclude(0);
  end
endmodule
